// ---- hw/epw_params.svh ----
// Purpose: constants of the watermark, interrupt-enable and gap register block
// Assumes: byte addresses on a 16-bit register port, 32-bit data
// Notes: offsets, alias selectors, access sizes, field positions, masks and reset values only
`ifndef EPW_PARAMS_SVH
`define EPW_PARAMS_SVH

// ****************************************************************
// register base offsets
// ****************************************************************
`define EPW_OFF_RXWM 16'h9050
`define EPW_OFF_IEN 16'h9060
`define EPW_OFF_CTRL 16'h9070
`define EPW_OFF_STAT 16'h9080
`define EPW_OFF_IPGT 16'h9220
`define EPW_OFF_IPGR 16'h9230
`define EPW_OFF_MRDD 16'h92C0
`define EPW_OFF_MIND 16'h92D0
`define EPW_OFF_SA0 16'h9300
`define EPW_OFF_SA1 16'h9310
`define EPW_OFF_SA2 16'h9320

// ****************************************************************
// alias selectors in address bits 3:2
// ****************************************************************
`define EPW_ALIAS_BASE 2'h0
`define EPW_ALIAS_CLR 2'h1
`define EPW_ALIAS_SET 2'h2
`define EPW_ALIAS_INV 2'h3

// ****************************************************************
// access sizes on the size port
// ****************************************************************
`define EPW_SIZE_BYTE 2'h0
`define EPW_SIZE_HALF 2'h1
`define EPW_SIZE_WORD 2'h2

// ****************************************************************
// implemented bits and reset values
// ****************************************************************
`define EPW_MASK_RXWM 32'h00FF00FF
`define EPW_MASK_IEN 32'h000063EF
`define EPW_MASK_CTRL 32'h00000001
`define EPW_MASK_IPGT 32'h0000007F
`define EPW_MASK_IPGR 32'h00007F7F
`define EPW_MASK_SA 32'h0000FFFF
`define EPW_RST_IPGT 32'h00000012
`define EPW_RST_IPGR 32'h00000C12
`define EPW_RST_ZERO 32'h00000000

// ****************************************************************
// field positions
// ****************************************************************
`define EPW_FULL_MARK_LSB 16
`define EPW_EMPTY_MARK_LSB 0
`define EPW_PART1_LSB 8
`define EPW_PART2_LSB 0
`define EPW_IEN_EMPTY_BIT 9
`define EPW_IEN_FULL_BIT 8

`endif

// ---- hw/epw_pkg.sv ----
// Purpose: shared types of the watermark and gap register block
// Assumes: nothing beyond the params header
// Notes: numbers live in the header, types live here
package epw_pkg;

  // ****************************************************************
  // interpacket gap timer states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    GAP_READY,
    GAP_B2B,
    GAP_PART1,
    GAP_PART2,
    GAP_DEFER
  } epw_gap_state_t;

endpackage

// ---- hw/epw_mark_detect.sv ----
// Purpose: receive buffer watermark compare and automatic flow control
// Assumes: buffer count comes from logic on the same clock
// Notes: events are one-cycle pulses on the rising edge of each condition
`timescale 1ns/1ns
`default_nettype none
module epw_mark_detect
  import epw_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] count_in,
  input wire logic [W-1:0] full_mark_in,
  input wire logic [W-1:0] empty_mark_in,
  input wire logic auto_flow_in,
  output logic full_level_out,
  output logic empty_level_out,
  output logic full_event_out,
  output logic empty_event_out,
  output logic flow_on_out
);

  logic full_now; // combinational full condition
  logic empty_now; // combinational empty condition
  logic full_q; // registered full condition
  logic empty_q; // registered empty condition
  logic flow_q; // flow control active

  assign full_now = (count_in >= full_mark_in);
  assign empty_now = (count_in <= empty_mark_in);

  // condition history, edges become events
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      full_q <= 1'b0;
      empty_q <= 1'b0;
    end
    else
    begin
      full_q <= full_now;
      empty_q <= empty_now;
    end
  end

  // flow control: full turns it on, empty turns it off
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !auto_flow_in)
      flow_q <= 1'b0;
    else if (full_now && !full_q)
      flow_q <= 1'b1;
    else if (empty_now && !empty_q)
      flow_q <= 1'b0;
  end

  assign full_level_out = full_q;
  assign empty_level_out = empty_q;
  assign full_event_out = full_now && !full_q;
  assign empty_event_out = empty_now && !empty_q;
  assign flow_on_out = flow_q;

endmodule
`default_nettype wire

// ---- hw/epw_gap_timer.sv ----
// Purpose: back-to-back and non-back-to-back interpacket gap timing
// Assumes: nibble tick and frame end come from the transmit logic, carrier is synchronised
// Notes: counts saturate, a gap field of zero expires at once
`timescale 1ns/1ns
`default_nettype none
module epw_gap_timer
  import epw_pkg::*;
#(
  parameter int CW = 7
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic nibble_tick_in,
  input wire logic frame_end_in,
  input wire logic back_to_back_in,
  input wire logic carrier_in,
  input wire logic [CW-1:0] b2b_gap_in,
  input wire logic [CW-1:0] part1_in,
  input wire logic [CW-1:0] part2_in,
  output logic tx_allow_out,
  output logic tx_defer_out
);

  epw_gap_state_t state_q; // gap timer state
  logic [CW-1:0] count_q; // nibble times elapsed
  logic [CW-1:0] count_inc; // saturating increment

  assign count_inc = (&count_q) ? count_q : CW'(count_q + 1'b1);

  // gap state machine, a frame end, or a carrier in part one or when ready, restarts timing
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= GAP_READY;
      count_q <= '0;
    end
    else if (frame_end_in)
    begin
      count_q <= '0;
      state_q <= back_to_back_in ? GAP_B2B : GAP_PART1;
    end
    else
    begin
      case (state_q)
        GAP_READY:
        begin
          // medium busy after the gap: defer and time the gap again
          if (carrier_in)
            state_q <= GAP_DEFER;
          count_q <= '0;
        end
        GAP_B2B:
        begin
          if (count_q >= b2b_gap_in)
            state_q <= GAP_READY;
          else if (nibble_tick_in)
            count_q <= count_inc;
        end
        GAP_PART1:
        begin
          if (carrier_in)
          begin
            state_q <= GAP_DEFER;
            count_q <= '0;
          end
          else if (count_q >= part1_in)
            state_q <= GAP_PART2;
          else if (nibble_tick_in)
            count_q <= count_inc;
        end
        GAP_PART2:
        begin
          // carrier ignored here on purpose: fair access over collision
          if (count_q >= part2_in)
            state_q <= GAP_READY;
          else if (nibble_tick_in)
            count_q <= count_inc;
        end
        GAP_DEFER:
        begin
          count_q <= '0;
          if (!carrier_in)
            state_q <= GAP_PART1;
        end
        default:
        begin
          state_q <= GAP_READY;
          count_q <= '0;
        end
      endcase
    end
  end

  assign tx_allow_out = (state_q == GAP_READY) && !carrier_in;
  assign tx_defer_out = (state_q == GAP_DEFER);

endmodule
`default_nettype wire

// ---- hw/epw_regs.sv ----
// Purpose: watermark, interrupt enable, gap and station address registers
// Assumes: single clock, synchronous reset, one-cycle read latency port
// Notes: base registers carry clear, set and invert aliases at +4, +8, +C
//
// What this block does
// - full mark compare raises event, starts flow
// - empty mark compare raises event, stops flow
// - bus error interrupts gated by bits 14, 13
// - watermark interrupts gated by bits 9, 8
// - receive events gated by bits 7,6,5,1,0
// - transmit done, abort gated by bits 3, 2
// - unimplemented enable bits read as zero
// - back-to-back gap field sets minimum gap
// - back-to-back gap resets to 0x12
// - carrier in part one makes transmitter defer
// - carrier in part two, off by gap end, still transmits
// - part two field is the gap, reset 0x12
// - gap registers take 16/32-bit, ignore 8-bit
// - clear, set, invert aliases at +4,+8,+C
// - station address loads factory value on reset
// - aliases modify only one bits, read as zero
`timescale 1ns/1ns
`default_nettype none
`include "epw_params.svh"
module epw_regs
  import epw_pkg::*;
#(
  parameter logic [47:0] FACTORY_ADDR = 48'h02_00_00_00_00_01, // arbitrary value
  parameter int MW = 8,
  parameter int GW = 7
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic [1:0] bus_size_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  input wire logic [MW-1:0] rx_buffer_count_in,
  input wire logic [14:0] irq_event_in,
  output logic [14:0] irq_req_out,
  input wire logic [15:0] mgmt_rdata_in,
  input wire logic [3:0] mgmt_ind_in,
  input wire logic tx_nibble_tick_in,
  input wire logic tx_frame_end_in,
  input wire logic tx_back_to_back_in,
  input wire logic phy_carrier_in,
  output logic tx_allow_out,
  output logic tx_defer_out,
  output logic flow_ctrl_on_out,
  output logic [47:0] station_addr_out
);

  // ****************************************************************
  // register table
  // ****************************************************************

  localparam int NREG = 8; // writable base registers
  localparam logic [3:0] NO_SLOT = 4'hF; // decode miss

  // slot order: watermarks, enables, b2b gap, nb2b gap, sa0..sa2, ctrl
  localparam logic [15:0] REG_BASE [NREG] = '{
    `EPW_OFF_RXWM, `EPW_OFF_IEN, `EPW_OFF_IPGT, `EPW_OFF_IPGR,
    `EPW_OFF_SA0, `EPW_OFF_SA1, `EPW_OFF_SA2, `EPW_OFF_CTRL
  };

  // implemented bits of each slot, the rest store and read as zero
  localparam logic [31:0] REG_MASK [NREG] = '{
    `EPW_MASK_RXWM, `EPW_MASK_IEN, `EPW_MASK_IPGT, `EPW_MASK_IPGR,
    `EPW_MASK_SA, `EPW_MASK_SA, `EPW_MASK_SA, `EPW_MASK_CTRL
  };

  // reset values, station address taken from the factory value
  localparam logic [31:0] REG_RST [NREG] = '{
    `EPW_RST_ZERO, `EPW_RST_ZERO, `EPW_RST_IPGT, `EPW_RST_IPGR,
    {16'h0000, FACTORY_ADDR[15:0]},
    {16'h0000, FACTORY_ADDR[31:16]},
    {16'h0000, FACTORY_ADDR[47:32]},
    `EPW_RST_ZERO
  };

  // slots that refuse byte writes (the two gap registers)
  localparam logic [NREG-1:0] REG_NO_BYTE = 8'h0C;

  // ****************************************************************
  // decode functions
  // ****************************************************************

  // slot of a writable register, alias bits ignored
  function automatic logic [3:0] find_slot(input logic [15:0] a);
    logic [3:0] s;
    s = NO_SLOT;
    for (int i = 0; i < NREG; i++)
    begin
      if ({a[15:4], 4'h0} == REG_BASE[i])
        s = 4'(i);
    end
    return s;
  endfunction

  // byte lanes touched by an access of the given size
  function automatic logic [31:0] lane_mask(input logic [1:0] size,
                                            input logic [1:0] lo);
    logic [31:0] m;
    m = 32'h00000000;
    case (size)
      `EPW_SIZE_WORD: m = 32'hFFFFFFFF;
      `EPW_SIZE_HALF: m = lo[1] ? 32'hFFFF0000 : 32'h0000FFFF;
      `EPW_SIZE_BYTE: m = 32'h000000FF << {lo, 3'h0};
      default: m = 32'h00000000;
    endcase
    return m;
  endfunction

  // base write or alias operation on the touched bits only
  function automatic logic [31:0] alias_apply(input logic [1:0] op,
                                              input logic [31:0] cur,
                                              input logic [31:0] data,
                                              input logic [31:0] lane);
    logic [31:0] d;
    logic [31:0] r;
    d = data & lane;
    r = cur;
    case (op)
      `EPW_ALIAS_BASE: r = (cur & ~lane) | d;
      `EPW_ALIAS_CLR: r = cur & ~d;
      `EPW_ALIAS_SET: r = cur | d;
      `EPW_ALIAS_INV: r = cur ^ d;
      default: r = cur;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // write path
  // ****************************************************************

  logic [31:0] reg_q [NREG]; // base register storage
  logic [3:0] wr_slot; // decoded write target
  logic [1:0] wr_op; // alias selector of the access
  logic [31:0] wr_lane; // byte lanes of the access
  logic wr_is_byte; // access is 8-bit

  assign wr_slot = find_slot(bus_addr_in);
  assign wr_op = bus_addr_in[3:2];
  assign wr_lane = lane_mask(bus_size_in, bus_addr_in[1:0]);
  assign wr_is_byte = (bus_size_in == `EPW_SIZE_BYTE);

  // one storage process per slot, masked to implemented bits
  generate
    for (genvar g = 0; g < NREG; g++)
    begin : gen_reg
      logic [31:0] lane_g; // lanes after the byte-refusal check

      // gap registers drop byte accesses entirely
      assign lane_g = (REG_NO_BYTE[g] && wr_is_byte) ? 32'h00000000 : wr_lane;

      always_ff @(posedge sys_clk_in)
      begin
        if (srst_in)
          reg_q[g] <= REG_RST[g];
        else if (bus_wr_in && (wr_slot == 4'(g)))
          reg_q[g] <= alias_apply(wr_op, reg_q[g], bus_wdata_in, lane_g) & REG_MASK[g];
      end
    end
  endgenerate

  // ****************************************************************
  // field extraction
  // ****************************************************************

  logic [MW-1:0] full_mark; // full watermark field
  logic [MW-1:0] empty_mark; // empty watermark field
  logic [14:0] irq_enable; // implemented enable bits
  logic [GW-1:0] b2b_gap; // back-to-back gap field
  logic [GW-1:0] part1_gap; // carrier window part
  logic [GW-1:0] part2_gap; // non-back-to-back gap part
  logic auto_flow; // automatic flow control enable

  assign full_mark = reg_q[0][`EPW_FULL_MARK_LSB +: MW];
  assign empty_mark = reg_q[0][`EPW_EMPTY_MARK_LSB +: MW];
  assign irq_enable = reg_q[1][14:0];
  assign b2b_gap = reg_q[2][GW-1:0];
  assign part1_gap = reg_q[3][`EPW_PART1_LSB +: GW];
  assign part2_gap = reg_q[3][`EPW_PART2_LSB +: GW];
  assign auto_flow = reg_q[7][0];

  // ****************************************************************
  // watermarks and flow control
  // ****************************************************************

  logic full_level; // buffer count at or above full mark
  logic empty_level; // buffer count at or below empty mark
  logic full_event; // pulse on entering full
  logic empty_event; // pulse on entering empty

  // compare assumes full mark above empty mark, else flow can chatter
  epw_mark_detect #(
    .W(MW)
  ) u_marks (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .count_in(rx_buffer_count_in),
    .full_mark_in(full_mark),
    .empty_mark_in(empty_mark),
    .auto_flow_in(auto_flow),
    .full_level_out(full_level),
    .empty_level_out(empty_level),
    .full_event_out(full_event),
    .empty_event_out(empty_event),
    .flow_on_out(flow_ctrl_on_out)
  );

  // ****************************************************************
  // interrupt gating
  // ****************************************************************

  logic [14:0] irq_source; // raw events with watermark bits merged
  logic [14:0] irq_q; // gated requests

  // watermark events come from the compare, not from outside
  always_comb
  begin
    irq_source = irq_event_in;
    irq_source[`EPW_IEN_EMPTY_BIT] = empty_event;
    irq_source[`EPW_IEN_FULL_BIT] = full_event;
  end

  // each event passes only while its own enable bit is one
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      irq_q <= 15'h0000;
    else
      irq_q <= irq_source & irq_enable;
  end

  assign irq_req_out = irq_q;

  // ****************************************************************
  // carrier synchroniser
  // ****************************************************************

  logic carrier_meta_q; // first stage, read only by the second
  logic carrier_q; // synchronised carrier

  // carrier comes from the phy pin, unrelated to this clock
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      carrier_meta_q <= 1'b0;
      carrier_q <= 1'b0;
    end
    else
    begin
      carrier_meta_q <= phy_carrier_in;
      carrier_q <= carrier_meta_q;
    end
  end

  // ****************************************************************
  // interpacket gap timer
  // ****************************************************************

  // duplex offsets are software's job, hardware counts the raw field
  epw_gap_timer #(
    .CW(GW)
  ) u_gap (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .nibble_tick_in(tx_nibble_tick_in),
    .frame_end_in(tx_frame_end_in),
    .back_to_back_in(tx_back_to_back_in),
    .carrier_in(carrier_q),
    .b2b_gap_in(b2b_gap),
    .part1_in(part1_gap),
    .part2_in(part2_gap),
    .tx_allow_out(tx_allow_out),
    .tx_defer_out(tx_defer_out)
  );

  // ****************************************************************
  // status word
  // ****************************************************************

  logic [31:0] status_word; // read-only block state

  // no aliases on this one, writes anywhere near it are dropped
  assign status_word = {27'h0000000, tx_defer_out, tx_allow_out,
                        empty_level, full_level, flow_ctrl_on_out};

  // ****************************************************************
  // read path
  // ****************************************************************

  logic [3:0] rd_slot; // decoded read target
  logic [31:0] rdata_q; // read data, valid one cycle only

  assign rd_slot = find_slot(bus_addr_in);

  // alias reads and unmapped reads answer zero
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      rdata_q <= 32'h00000000;
    else if (!bus_rd_in)
      rdata_q <= 32'h00000000;
    else if (bus_addr_in[3:2] != `EPW_ALIAS_BASE)
      rdata_q <= 32'h00000000;
    else if (rd_slot != NO_SLOT)
      rdata_q <= reg_q[rd_slot[2:0]];
    else
    begin
      case (bus_addr_in)
        `EPW_OFF_MRDD: rdata_q <= {16'h0000, mgmt_rdata_in};
        `EPW_OFF_MIND: rdata_q <= {28'h0000000, mgmt_ind_in};
        `EPW_OFF_STAT: rdata_q <= status_word;
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign bus_rdata_out = rdata_q;

  // ****************************************************************
  // station address out
  // ****************************************************************

  // first address byte in the top bits
  assign station_addr_out = {reg_q[6][15:0], reg_q[5][15:0], reg_q[4][15:0]};

endmodule
`default_nettype wire

// ---- verif/epw_regs_checker.sv ----
// Purpose: port assertions of the register block
// Assumes: bound to epw_regs, one clock, gap fields never zero
// Notes: reads, irq gating, gap timer
`timescale 1ns/1ns
`default_nettype none
`include "epw_params.svh"
module epw_regs_checker
#(
  parameter logic [47:0] FACTORY_ADDR = 48'h0
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_rd_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic [14:0] irq_event_in,
  input wire logic [14:0] irq_req_out,
  input wire logic tx_frame_end_in,
  input wire logic tx_back_to_back_in,
  input wire logic phy_carrier_in,
  input wire logic tx_allow_out,
  input wire logic tx_defer_out,
  input wire logic [47:0] station_addr_out
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // alias reads give nothing back
  property p_alias_rd; bus_rd_in && bus_addr_in[3:2] != 2'h0 |=> bus_rdata_out == 32'h0; endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read not zero");
  property p_ien_rd; bus_rd_in && bus_addr_in == `EPW_OFF_IEN |=> (bus_rdata_out & ~`EPW_MASK_IEN) == 32'h0; endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("enable unused bits set");
  property p_sa_rd; bus_rd_in && bus_addr_in[15:8] == 8'h93 && bus_addr_in[3:0] == 4'h0 |=> bus_rdata_out[31:16] == 16'h0; endproperty
  a_sa_rd: assert property (p_sa_rd) else $error("address upper bits set");
  // request needs its raw event a cycle before
  property p_irq_gate; (irq_req_out & ~$past(irq_event_in) & 15'h7CFF) == 15'h0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without event");
  property p_irq_unimpl; irq_req_out[12:10] == 3'h0 && !irq_req_out[4]; endproperty
  a_irq_unimpl: assert property (p_irq_unimpl) else $error("unused request bit");
  property p_defer_excl; tx_defer_out |-> !tx_allow_out; endproperty
  a_defer_excl: assert property (p_defer_excl) else $error("allow while deferring");
  // carrier passes two sync flops
  property p_defer_cause; $rose(tx_defer_out) |-> $past(phy_carrier_in, 2) || $past(phy_carrier_in, 3); endproperty
  a_defer_cause: assert property (p_defer_cause) else $error("defer without carrier");
  property p_frame_stop; tx_frame_end_in |=> !tx_allow_out; endproperty
  a_frame_stop: assert property (p_frame_stop) else $error("allow right after frame");
  property p_b2b_min; tx_frame_end_in && tx_back_to_back_in |=> !tx_allow_out [*3]; endproperty
  a_b2b_min: assert property (p_b2b_min) else $error("gap too short");
  property p_sa_reset; $fell(srst_in) |-> station_addr_out == FACTORY_ADDR; endproperty
  a_sa_reset: assert property (p_sa_reset) else $error("address not loaded");
  c_defer: cover property (tx_defer_out);
  c_full: cover property (irq_req_out[8]);
  c_allow: cover property ($rose(tx_allow_out));
endmodule
`default_nettype wire

// ---- verif/epw_phy_model.sv ----
// Purpose: far-side nibble ticks and carrier
// Assumes: tick every TICK_DIV cycles
// Notes: tick stands still in reset
`timescale 1ns/1ns
`default_nettype none
module epw_phy_model
#(
  parameter int TICK_DIV = 4
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic carrier_req_in,
  output logic nibble_tick_out,
  output logic carrier_out
);
  // ****************
  // nibble divider
  // ****************
  logic [3:0] div_q; // cycles within one nibble time
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || div_q == 4'(TICK_DIV - 1))
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end
  assign nibble_tick_out = (div_q == 4'h0) && !srst_in;
  // registered carrier, bench decides when the medium is busy
  always_ff @(posedge sys_clk_in)
  begin
    carrier_out <= carrier_req_in && !srst_in;
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the register block
// Assumes: phy model ticks every four cycles
// Notes: port tasks and gap runs
`timescale 1ns/1ns
`default_nettype none
`include "epw_params.svh"
module testbench;
  // ****************
  // signals
  // ****************
  localparam logic [47:0] FA = 48'h0A1B2C3D4E5F; // arbitrary value
  localparam logic [15:0] IE = `EPW_OFF_IEN;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] size = `EPW_SIZE_WORD;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] cnt = 8'h0;
  logic [14:0] ev = 15'h0;
  logic fend = 1'b0;
  logic b2b = 1'b0;
  logic creq = 1'b0;
  logic [31:0] rdata;
  logic [14:0] irq;
  logic tick, carr, allow, defer, flow, ds, s;
  logic [47:0] sa;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int tk;
  initial forever #5 sys_clk_in = ~sys_clk_in;
  epw_regs #(.FACTORY_ADDR(FA)) dut
  (
    .sys_clk_in, .srst_in, .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_size_in(size), .bus_wr_in(wr), .bus_rd_in(rd_s), .bus_rdata_out(rdata),
    .rx_buffer_count_in(cnt), .irq_event_in(ev), .irq_req_out(irq),
    .mgmt_rdata_in(16'hA5C3), .mgmt_ind_in(4'h9), .tx_nibble_tick_in(tick),
    .tx_frame_end_in(fend), .tx_back_to_back_in(b2b), .phy_carrier_in(carr),
    .tx_allow_out(allow), .tx_defer_out(defer), .flow_ctrl_on_out(flow), .station_addr_out(sa)
  );
  epw_phy_model phy
  (
    .sys_clk_in, .srst_in, .carrier_req_in(creq),
    .nibble_tick_out(tick), .carrier_out(carr)
  );
  // ****************
  // tasks
  // ****************
  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [31:0] d, input logic [1:0] sz = `EPW_SIZE_WORD);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    size <= sz;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    size <= `EPW_SIZE_WORD;
    rd_s <= 1'b1;
    @(posedge sys_clk_in);
    rd_s <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, rdata);
  endtask
  task pulse(input logic [14:0] e);
    @(posedge sys_clk_in);
    ev <= 15'h7FFF;
    @(posedge sys_clk_in);
    ev <= 15'h0;
    #1;
    chk("irq", e, irq);
  endtask
  task scan(input int b);
    s = 1'b0;
    repeat (4)
    begin
      @(posedge sys_clk_in);
      #1;
      s = s | (irq[b] === 1'b1);
    end
  endtask
  // frame end after a tick, count ticks until allowed
  task gap(input logic bb, input int con, input int coff);
    int n;
    tk = 0;
    ds = 1'b0;
    @(posedge sys_clk_in);
    #1;
    while (tick !== 1'b1)
    begin
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    fend <= 1'b1;
    b2b <= bb;
    @(posedge sys_clk_in);
    fend <= 1'b0;
    for (n = 0; n < 400; n++)
    begin
      #1;
      ds = ds | (defer === 1'b1);
      if (allow === 1'b1)
        break;
      if (tick === 1'b1)
        tk++;
      @(posedge sys_clk_in);
      creq <= (tk >= con) && (tk < coff);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, run needs a few hundred cycles
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rd_reg(`EPW_OFF_RXWM, 32'h0);
    rd_reg(`EPW_OFF_IPGT, 32'h12);
    rd_reg(`EPW_OFF_IPGR, 32'hC12);
    rd_reg(`EPW_OFF_SA1, {16'h0, FA[31:16]});
    wr_reg(`EPW_OFF_MRDD, 32'h0);
    rd_reg(`EPW_OFF_MRDD, 32'hA5C3);
    rd_reg(`EPW_OFF_MIND, 32'h9);
    wr_reg(`EPW_OFF_SA0, 32'hFFFFFFFF);
    rd_reg(`EPW_OFF_SA0, 32'hFFFF);
    chk("station", {FA[47:16], 16'hFFFF}, sa);
    $display("test registers done");
    wr_reg(IE, 32'hFFFFFFFF);
    rd_reg(IE, 32'h63EF);
    wr_reg(IE | 16'h4, 32'h0303);
    wr_reg(IE | 16'h8, 32'h0010);
    rd_reg(IE, 32'h60EC);
    wr_reg(IE | 16'hC, 32'h4001);
    rd_reg(IE, 32'h20ED);
    rd_reg(IE | 16'hC, 32'h0);
    pulse(15'h20ED);
    wr_reg(IE | 16'hC, 32'h6000);
    pulse(15'h40ED);
    $display("test enables done");
    wr_reg(`EPW_OFF_IPGT, 32'h55, `EPW_SIZE_BYTE);
    rd_reg(`EPW_OFF_IPGT, 32'h12);
    wr_reg(`EPW_OFF_IPGT, 32'h02, `EPW_SIZE_HALF);
    rd_reg(`EPW_OFF_IPGT, 32'h02);
    wr_reg(`EPW_OFF_IPGR, 32'h0206, `EPW_SIZE_HALF);
    wr_reg(`EPW_OFF_IPGR | 16'h4, 32'h7F, `EPW_SIZE_BYTE);
    rd_reg(`EPW_OFF_IPGR, 32'h0206);
    gap(1'b1, 999, 0);
    chk("b2b ticks", 2, tk);
    gap(1'b0, 999, 0);
    chk("nb2b ticks", 6, tk);
    gap(1'b0, 3, 4);
    chk("late carrier ticks", 6, tk);
    chk("late carrier defer", 0, ds);
    wr_reg(`EPW_OFF_IPGR, 32'h0C12);
    gap(1'b0, 1, 3);
    chk("early carrier defer", 1, ds);
    $display("test gaps done");
    wr_reg(`EPW_OFF_RXWM, 32'h00100004);
    wr_reg(`EPW_OFF_CTRL, 32'h1);
    wr_reg(IE | 16'h8, 32'h0300);
    cnt <= 8'h08;
    @(posedge sys_clk_in);
    cnt <= 8'h10;
    scan(8);
    chk("full irq", 1, s);
    chk("flow on", 1, flow);
    cnt <= 8'h04;
    scan(9);
    chk("empty irq", 1, s);
    chk("flow off", 0, flow);
    cnt <= 8'h10;
    scan(8);
    wr_reg(`EPW_OFF_CTRL | 16'h4, 32'h1);
    @(posedge sys_clk_in);
    #1;
    chk("flow manual", 0, flow);
    $display("test watermarks done");
    stop_test();
  end
endmodule
bind epw_regs epw_regs_checker #(.FACTORY_ADDR(FACTORY_ADDR)) u_chk
(
  .sys_clk_in, .srst_in, .bus_addr_in, .bus_rd_in, .bus_rdata_out, .irq_event_in, .irq_req_out,
  .tx_frame_end_in, .tx_back_to_back_in, .phy_carrier_in, .tx_allow_out, .tx_defer_out,
  .station_addr_out
);
`default_nettype wire
